// ==== src/rfd_top.sv ====
// Request flag decoder top: byte stream parse and Avalon-MM registers
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module rfd_top
  import rfd_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic RX_SOF,
  input wire logic RX_BYTE_VALID,
  input wire logic [7:0] RX_BYTE,
  input wire logic RX_EOF,
  output logic REQ_DONE,
  output logic REQ_EXECUTE,
  output logic [7:0] REQ_CMD,
  output logic [7:0] REQ_AFI,
  output logic TX_TWO_SUBCARRIERS,
  output logic TX_HIGH_RATE,
  output logic [7:0] TX_RESP_FLAGS,
  output logic [7:0] TX_ERR_CODE,
  output logic TX_ERR_PRESENT
);
  // Registers
  logic [2:0] err_kind_reg;
  logic selected_reg;
  logic generic_reg;
  logic [7:0] own_uid_reg;
  logic [7:0] flags_reg;
  logic [7:0] cmd_reg;
  logic [7:0] afi_reg;
  logic uid_match_reg;
  logic [3:0] uid_cnt_reg;
  logic done_reg;
  logic exec_reg;
  logic [31:0] rdata_reg;
  logic ack_reg;
  rfd_frame_state_t state_reg;
  rfd_frame_state_t state_next;

  rfd_decode_t dec;
  rfd_resp_t resp;

  rfd_flag_decode u_dec (
    .flags(flags_reg),
    .dec(dec)
  );

  rfd_resp_build u_resp (
    .err_kind(err_kind_reg),
    .resp(resp)
  );

  // Bus decode
  wire req = AVS_READ | AVS_WRITE;
  // Writes land at the edge where waitrequest is low
  wire wr_ctrl = AVS_WRITE & ack_reg & (AVS_ADDRESS == ADDR_CTRL) & AVS_BYTEENABLE[0];
  wire wr_uid = AVS_WRITE & ack_reg & (AVS_ADDRESS == ADDR_CTRL) & AVS_BYTEENABLE[1];
  wire [31:0] ctrl_word = {16'h0000, own_uid_reg, 3'h0, generic_reg, selected_reg, err_kind_reg};
  wire [31:0] rd_mux = (AVS_ADDRESS == ADDR_CTRL) ? ctrl_word :
    (AVS_ADDRESS == ADDR_FLAGS) ? {8'h00, afi_reg, cmd_reg, flags_reg} :
    (AVS_ADDRESS == ADDR_DECODE) ? {18'h00000, dec} :
    (AVS_ADDRESS == ADDR_RESP) ? {15'h0000, resp} : READ_UNMAPPED;
  assign AVS_WAITREQUEST = req & ~ack_reg;
  assign AVS_READDATA = rdata_reg;

  // Frame parse: flags, command, then optional UID or family byte
  wire uid_byte_last = (uid_cnt_reg == 4'h7);
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      FR_IDLE: if (RX_SOF) state_next = FR_FLAGS;
      FR_FLAGS: if (RX_BYTE_VALID) state_next = FR_CMD;
      FR_CMD: if (RX_BYTE_VALID) begin
        if (dec.uid_present) state_next = FR_UID;
        else if (dec.app_family_present) state_next = FR_AFI;
        else state_next = FR_BODY;
      end
      FR_UID: if (RX_BYTE_VALID & uid_byte_last) state_next = FR_BODY;
      FR_AFI: if (RX_BYTE_VALID) state_next = FR_BODY;
      FR_BODY: state_next = FR_BODY;
      default: state_next = FR_IDLE;
    endcase
    if (RX_EOF) state_next = FR_IDLE;
    if (RX_SOF) state_next = FR_FLAGS;
  end

  // Execution filter
  wire exec_ok = ~dec.format_error & (~dec.select_only | selected_reg) & (~dec.uid_present | uid_match_reg);
  wire uid_ok = (RX_BYTE == own_uid_reg) | (uid_cnt_reg != 4'h0);

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      state_reg <= FR_IDLE;
      flags_reg <= BYTE_ZERO;
      cmd_reg <= BYTE_ZERO;
      afi_reg <= BYTE_ZERO;
      uid_cnt_reg <= 4'h0;
      uid_match_reg <= 1'b0;
      done_reg <= 1'b0;
      exec_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      done_reg <= RX_EOF & (state_reg != FR_IDLE) & (state_reg != FR_FLAGS);
      exec_reg <= RX_EOF & (state_reg != FR_IDLE) & (state_reg != FR_FLAGS) & exec_ok;
      if (state_reg == FR_FLAGS && RX_BYTE_VALID) begin
        flags_reg <= RX_BYTE;
        uid_cnt_reg <= 4'h0;
        uid_match_reg <= 1'b1;
      end
      if (state_reg == FR_CMD && RX_BYTE_VALID) cmd_reg <= RX_BYTE;
      if (state_reg == FR_AFI && RX_BYTE_VALID) afi_reg <= RX_BYTE;
      if (state_reg == FR_UID && RX_BYTE_VALID) begin
        uid_cnt_reg <= uid_cnt_reg + 4'h1;
        uid_match_reg <= uid_match_reg & uid_ok;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      err_kind_reg <= ERRK_NONE;
      selected_reg <= 1'b0;
      generic_reg <= 1'b0;
      own_uid_reg <= BYTE_ZERO;
      rdata_reg <= READ_UNMAPPED;
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req & ~ack_reg;
      if (AVS_READ & ~ack_reg) rdata_reg <= rd_mux;
      if (wr_ctrl) begin
        err_kind_reg <= AVS_WRITEDATA[2:0];
        selected_reg <= AVS_WRITEDATA[3];
        generic_reg <= AVS_WRITEDATA[4];
      end
      if (wr_uid) own_uid_reg <= AVS_WRITEDATA[15:8];
    end
  end

  // Generic error overrides the selected kind
  wire [7:0] flags_out = generic_reg ? RESP_FLAG_ERROR : resp.flags;
  wire [7:0] code_out = generic_reg ? ERR_GENERIC : resp.code;
  wire present_out = generic_reg | resp.code_present;

  // Outputs
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      TX_TWO_SUBCARRIERS <= 1'b0;
      TX_HIGH_RATE <= 1'b0;
      TX_RESP_FLAGS <= RESP_FLAG_OK;
      TX_ERR_CODE <= BYTE_ZERO;
      TX_ERR_PRESENT <= 1'b0;
    end else begin
      TX_TWO_SUBCARRIERS <= dec.two_subcarriers;
      TX_HIGH_RATE <= dec.high_rate;
      TX_RESP_FLAGS <= flags_out;
      TX_ERR_CODE <= code_out;
      TX_ERR_PRESENT <= present_out;
    end
  end

  assign REQ_DONE = done_reg;
  assign REQ_EXECUTE = exec_reg;
  assign REQ_CMD = cmd_reg;
  assign REQ_AFI = afi_reg;
endmodule
`default_nettype wire

// ==== include/rfd_pkg.sv ====
// Package for the RF request flag decoder: offsets, fields, codes, types
//
// Summary of operation
// - Request order: SOF, flags, command, parameters and data, CRC, EOF.
// - Request flags are one byte; bits 5 to 8 are decoded together with bit 3.
// - Flag bit 3 picks selection meaning or inventory meaning for bits 5 to 8.
// - Flag bit 1 picks one subcarrier (0) or two subcarriers (1) for replies.
// - Flag bit 2 picks low (0) or high (1) reply data rate.
// - Selection mode: bit 5 set means only a Selected device executes.
// - Selection mode: bit 6 set means UID follows; only the matching device executes. The code compares only the first UID byte with own_uid_reg.
// - Inventory mode: bit 5 set means an application family byte follows and is parsed.
// - Inventory mode: bit 6 clear gives sixteen slots, set gives one slot.
// - Response order: SOF, flags, parameters and data, CRC, EOF.
// - Device sends a one-byte response flags field.
// - Response bit 1 flags an error; an error code byte then follows.
// - Unsupported option gives code 03h; unspecified error gives 0Fh.
// - Codes 10h unavailable, 11h already locked, 12h locked block write.
// - Codes 13h program fail, 14h lock fail, 15h read protected.
// - Error codes outside the defined set are never emitted.
package rfd_pkg;
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_FLAGS = 4'h4;
  localparam logic [3:0] ADDR_DECODE = 4'h8;
  localparam logic [3:0] ADDR_RESP = 4'hC;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

  localparam int BIT_SUBCARRIER = 0;
  localparam int BIT_DATA_RATE = 1;
  localparam int BIT_INVENTORY = 2;
  localparam int BIT_PROTO_EXT = 3;
  localparam int BIT_SEL5 = 4;
  localparam int BIT_SEL6 = 5;
  localparam int BIT_OPTION = 6;
  localparam int BIT_RESERVED = 7;

  localparam logic [7:0] ERR_OPTION = 8'h03;
  localparam logic [7:0] ERR_GENERIC = 8'h0F;
  localparam logic [7:0] ERR_NO_BLOCK = 8'h10;
  localparam logic [7:0] ERR_RELOCK = 8'h11;
  localparam logic [7:0] ERR_LOCKED_WR = 8'h12;
  localparam logic [7:0] ERR_PROG_FAIL = 8'h13;
  localparam logic [7:0] ERR_LOCK_FAIL = 8'h14;
  localparam logic [7:0] ERR_READ_PROT = 8'h15;
  localparam logic [7:0] RESP_FLAG_ERROR = 8'h01;
  localparam logic [7:0] RESP_FLAG_OK = 8'h00;
  localparam logic [4:0] SLOTS_MANY = 5'h10;
  localparam logic [4:0] SLOTS_ONE = 5'h01;
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  typedef enum logic [2:0] {
    ERRK_NONE, ERRK_OPTION, ERRK_NO_BLOCK, ERRK_RELOCK,
    ERRK_LOCKED_WR, ERRK_PROG_FAIL, ERRK_LOCK_FAIL, ERRK_READ_PROT
  } rfd_err_kind_t;

  typedef struct packed {
    logic two_subcarriers;
    logic high_rate;
    logic inventory;
    logic select_only;
    logic uid_present;
    logic app_family_present;
    logic single_slot_select;
    logic option;
    logic [4:0] slot_total;
    logic format_error;
  } rfd_decode_t;

  typedef struct packed {
    logic [7:0] flags;
    logic [7:0] code;
    logic code_present;
  } rfd_resp_t;

  typedef enum logic [2:0] {
    FR_IDLE, FR_FLAGS, FR_CMD, FR_UID, FR_AFI, FR_BODY
  } rfd_frame_state_t;
endpackage

// ==== src/rfd_flag_decode.sv ====
// Combinational decode of the request flags byte
`timescale 1ns/1ns
`default_nettype none
module rfd_flag_decode
  import rfd_pkg::*;
(
  input wire logic [7:0] flags,
  output rfd_decode_t dec
);
  wire inv = flags[BIT_INVENTORY];
  wire fmt_err = flags[BIT_PROTO_EXT] | flags[BIT_RESERVED] | (inv & flags[BIT_OPTION]);

  assign dec.two_subcarriers = flags[BIT_SUBCARRIER];
  assign dec.high_rate = flags[BIT_DATA_RATE];
  assign dec.inventory = inv;
  assign dec.select_only = ~inv & flags[BIT_SEL5];
  assign dec.uid_present = ~inv & flags[BIT_SEL6] & ~flags[BIT_SEL5];
  assign dec.app_family_present = inv & flags[BIT_SEL5];
  assign dec.single_slot_select = inv & flags[BIT_SEL6];
  assign dec.option = ~inv & flags[BIT_OPTION];
  assign dec.slot_total = (inv & ~flags[BIT_SEL6]) ? SLOTS_MANY : SLOTS_ONE;
  assign dec.format_error = fmt_err | (~inv & flags[BIT_SEL5] & flags[BIT_SEL6]);
endmodule
`default_nettype wire

// ==== src/rfd_resp_build.sv ====
// Builds response flags byte and error code
`timescale 1ns/1ns
`default_nettype none
module rfd_resp_build
  import rfd_pkg::*;
(
  input wire logic [2:0] err_kind,
  output rfd_resp_t resp
);
  function automatic logic [7:0] err_code(input logic [2:0] k);
    case (k)
      ERRK_OPTION: err_code = ERR_OPTION;
      ERRK_NO_BLOCK: err_code = ERR_NO_BLOCK;
      ERRK_RELOCK: err_code = ERR_RELOCK;
      ERRK_LOCKED_WR: err_code = ERR_LOCKED_WR;
      ERRK_PROG_FAIL: err_code = ERR_PROG_FAIL;
      ERRK_LOCK_FAIL: err_code = ERR_LOCK_FAIL;
      ERRK_READ_PROT: err_code = ERR_READ_PROT;
      default: err_code = BYTE_ZERO;
    endcase
  endfunction

  wire is_err = (err_kind != ERRK_NONE);
  assign resp.flags = is_err ? RESP_FLAG_ERROR : RESP_FLAG_OK;
  assign resp.code = err_code(err_kind);
  assign resp.code_present = is_err;
endmodule
`default_nettype wire

// ==== tb/rfd_reader_model.sv ====
// Reader model that sends request frames into the decoder
`timescale 1ns/1ns
`default_nettype none
module rfd_reader_model (
  input wire logic SYS_CLK,
  output logic RX_SOF,
  output logic RX_BYTE_VALID,
  output logic [7:0] RX_BYTE,
  output logic RX_EOF
);
  initial begin
    {RX_SOF, RX_BYTE_VALID, RX_EOF} = 3'h0;
    RX_BYTE = 8'h5A;
  end
  // One symbol, then an idle cycle with the data line inverted
  task automatic put(input logic [2:0] k, input logic [7:0] b);
    @(posedge SYS_CLK);
    {RX_SOF, RX_BYTE_VALID, RX_EOF} <= k;
    RX_BYTE <= k[1] ? b : ~RX_BYTE;
    @(posedge SYS_CLK);
    {RX_SOF, RX_BYTE_VALID, RX_EOF} <= 3'h0;
    RX_BYTE <= ~b;
  endtask
  // Start, flags, command, extra bytes, end
  task automatic send(input logic [7:0] f, input logic [7:0] c, input logic [3:0] n, input logic [7:0] x);
    put(3'h4, 8'h00);
    put(3'h2, f);
    put(3'h2, c);
    for (int i = 0; i < n; i++) put(3'h2, x);
    put(3'h1, 8'h00);
  endtask
endmodule
`default_nettype wire

// ==== tb/rfd_top_checker.sv ====
// Assertions on the ports of the decoder top
`timescale 1ns/1ns
`default_nettype none
module rfd_top_checker import rfd_pkg::*; (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  input wire logic RX_SOF,
  input wire logic RX_BYTE_VALID,
  input wire logic [7:0] RX_BYTE,
  input wire logic RX_EOF,
  input wire logic REQ_DONE,
  input wire logic REQ_EXECUTE,
  input wire logic TX_TWO_SUBCARRIERS,
  input wire logic TX_HIGH_RATE,
  input wire logic [7:0] TX_RESP_FLAGS,
  input wire logic [7:0] TX_ERR_CODE,
  input wire logic TX_ERR_PRESENT
);
  logic wait_reg, got_reg;
  logic [7:0] fl_reg;
  // Tracks the flags byte of the current frame
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      {wait_reg, got_reg, fl_reg} <= 10'h000;
    end else if (RX_SOF) begin
      {wait_reg, got_reg} <= 2'h2;
    end else if (RX_BYTE_VALID && wait_reg) begin
      {wait_reg, got_reg, fl_reg} <= {2'h1, RX_BYTE};
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SYS_RST);
  a_done_after_eof: assert property (RX_EOF && got_reg |=> REQ_DONE) else $error("no done after end");
  a_done_has_cause: assert property (REQ_DONE |-> $past(RX_EOF)) else $error("done without end");
  a_exec_with_done: assert property (REQ_EXECUTE |-> REQ_DONE) else $error("execute without done");
  a_bad_bits_refused: assert property (RX_EOF && got_reg && (fl_reg[3] || fl_reg[7]) |=> !REQ_EXECUTE)
    else $error("bad flags executed");
  a_inv_option_refused: assert property (RX_EOF && got_reg && fl_reg[2] && fl_reg[6] |=> !REQ_EXECUTE)
    else $error("inventory option executed");
  a_reply_mode_follows: assert property (RX_BYTE_VALID && wait_reg |-> ##2
    {TX_TWO_SUBCARRIERS, TX_HIGH_RATE} == {$past(RX_BYTE[0], 2), $past(RX_BYTE[1], 2)})
    else $error("reply mode wrong");
  a_resp_upper_zero: assert property (TX_RESP_FLAGS[7:1] == 7'h00) else $error("response flags upper set");
  a_err_flag_code: assert property (TX_RESP_FLAGS[0] == TX_ERR_PRESENT) else $error("error flag mismatch");
  a_err_code_set: assert property (TX_ERR_PRESENT |-> TX_ERR_CODE inside {8'h03, 8'h0F, [8'h10:8'h15]})
    else $error("reserved error code");
  a_bus_one_wait: assert property ($rose(AVS_READ) || $rose(AVS_WRITE) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
    else $error("bus wait state wrong");
endmodule
bind rfd_top rfd_top_checker i_rfd_top_checker (.*);
`default_nettype wire

// ==== tb/rfd_top_bench.sv ====
// Self-checking bench for the request flag decoder
`timescale 1ns/1ns
`default_nettype none
module rfd_top_bench import rfd_pkg::*;;
  logic SYS_CLK = 1'b0;
  logic SYS_RST = 1'b1;
  logic [3:0] AVS_ADDRESS = 4'h0;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  logic [3:0] AVS_BYTEENABLE = 4'hF;
  logic [31:0] AVS_READDATA, q;
  logic AVS_WAITREQUEST, RX_SOF, RX_BYTE_VALID, RX_EOF, REQ_DONE, REQ_EXECUTE;
  logic [7:0] RX_BYTE, REQ_CMD, REQ_AFI, TX_RESP_FLAGS, TX_ERR_CODE;
  logic TX_TWO_SUBCARRIERS, TX_HIGH_RATE, TX_ERR_PRESENT;
  int fails = 0;
  int n_checks = 0;
  // Flags, extra byte count, execute, extra byte
  logic [23:0] rows [14] = '{24'h00_0_1_00, 24'h01_0_1_00, 24'h02_0_1_00, 24'h03_0_1_00, 24'h08_0_0_00,
    24'h80_0_0_00, 24'h10_0_0_00, 24'h30_0_0_00, 24'h20_8_1_A5, 24'h20_8_0_5A, 24'h04_0_1_00,
    24'h24_0_1_00, 24'h44_0_0_00, 24'h14_1_1_C3};
  logic [7:0] codes [8] = '{8'h00, 8'h03, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15};
  always #25 SYS_CLK = ~SYS_CLK;
  rfd_top i_rfd_top (.*);
  rfd_reader_model i_rfd_reader_model (.*);
  task automatic end_sim;
    $display("checks %0d, errors %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t ns: got %h expected %h", $time, g, e);
    end
  endtask
  // One bus transfer, held until the wait is lifted
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rd);
    int t;
    t = 0;
    @(posedge SYS_CLK);
    AVS_READ <= ~w;
    AVS_WRITE <= w;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    do begin
      @(posedge SYS_CLK);
      t++;
    end while (AVS_WAITREQUEST !== 1'b0 && t < 100);
    if (t >= 100) fails++;
    rd = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  initial begin
    #1000000;
    fails++;
    end_sim();
  end
  initial begin
    repeat (20) @(posedge SYS_CLK);
    chk({REQ_DONE, REQ_EXECUTE, TX_RESP_FLAGS, TX_ERR_PRESENT}, 32'h0);
    SYS_RST <= 1'b0;
    av(1'b1, ADDR_CTRL, 32'h0000_A500, q);
    for (int r = 0; r < 14; r++) begin
      i_rfd_reader_model.send(rows[r][23:16], 8'h20 + r[7:0], rows[r][15:12], rows[r][7:0]);
      @(negedge SYS_CLK);
      chk({REQ_DONE, REQ_EXECUTE}, {1'b1, rows[r][8]});
      chk(REQ_CMD, 8'h20 + r[7:0]);
      chk({TX_TWO_SUBCARRIERS, TX_HIGH_RATE}, {rows[r][16], rows[r][17]});
      if (rows[r][18]) begin
        av(1'b0, ADDR_DECODE, 32'h0, q);
        chk(q[5:1], rows[r][21] ? SLOTS_ONE : SLOTS_MANY);
      end
    end
    chk(REQ_AFI, 8'hC3);
    av(1'b1, ADDR_CTRL, 32'h0000_A508, q);
    i_rfd_reader_model.send(8'h10, 8'h33, 4'h0, 8'h00);
    @(negedge SYS_CLK);
    chk(REQ_EXECUTE, 1'b1);
    av(1'b0, ADDR_FLAGS, 32'h0, q);
    chk(q[15:0], 16'h3310);
    av(1'b0, 4'h2, 32'h0, q);
    chk(q, READ_UNMAPPED);
    for (int k = 0; k < 8; k++) begin
      av(1'b1, ADDR_CTRL, {16'h0000, 8'hA5, 5'h01, k[2:0]}, q);
      repeat (3) @(negedge SYS_CLK);
      chk({TX_RESP_FLAGS, TX_ERR_CODE, TX_ERR_PRESENT},
        {k ? RESP_FLAG_ERROR : RESP_FLAG_OK, codes[k], k != 0});
    end
    // Error without detail
    av(1'b1, ADDR_CTRL, 32'h0000_A510, q);
    repeat (3) @(negedge SYS_CLK);
    chk({TX_RESP_FLAGS, TX_ERR_CODE, TX_ERR_PRESENT}, {RESP_FLAG_ERROR, ERR_GENERIC, 1'b1});
    // Reset in mid-run
    @(posedge SYS_CLK);
    SYS_RST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    chk({REQ_CMD, REQ_AFI, TX_RESP_FLAGS, TX_ERR_CODE}, 32'h0);
    SYS_RST <= 1'b0;
    i_rfd_reader_model.send(8'h03, 8'h44, 4'h0, 8'h00);
    @(negedge SYS_CLK);
    chk({REQ_DONE, REQ_EXECUTE, TX_TWO_SUBCARRIERS, TX_HIGH_RATE}, 4'hF);
    end_sim();
  end
endmodule
`default_nettype wire
